// [rxpo_top.sv]
/*
  receive parallel output port: presents received characters on a
  parallel bus with a forwarded complementary clock, in full or half rate,
  reports self-test status, and flags a powered-down reclocker.
  assumes the recovered character clock and character bus arrive as pins
  from the link domain, and the self-test code comes from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rxpo_cfg.svh"

module rxpo_top
  import rxpo_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // link side
  input  wire logic        rx_char_clk,
  input  wire logic [9:0]  rx_char_in,
  input  wire logic [2:0]  selftest_code,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // host side
  output logic      [9:0]  rx_parallel_char_out,
  output logic             rx_forwarded_clock_p,
  output logic             rx_forwarded_clock_n,
  output logic             selftest_status_out,
  output logic             reclocker_off_flag,
  output logic             irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic       link_clk_s;
  rxpo_char_t char_s;

  rxpo_pin_sync #(
    .WIDTH (11)
  ) u_sync (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .pin_in   ({rx_char_clk, rx_char_in}),
    .pin_sync ({link_clk_s, char_s})
  );

  logic link_clk_d_r;
  logic link_rise;
  logic link_fall;

  always_ff @(posedge clk) begin
    if (reset) begin
      link_clk_d_r <= 1'b0;
    end else if (ce) begin
      link_clk_d_r <= link_clk_s;
    end
  end

  assign link_rise = link_clk_s & ~link_clk_d_r;
  assign link_fall = ~link_clk_s & link_clk_d_r;

  // ****************************************************************
  // control register
  // ****************************************************************
  logic [4:0] ctrl_r;
  logic [4:0] ctrl_nxt;
  logic       wr_ctrl;
  logic       half_rate;
  logic       selftest_on;
  logic       recl_off_nxt;

  assign wr_ctrl  = reg_wr & hit(reg_addr, `RXPO_OFS_CTRL);
  assign ctrl_nxt = wr_ctrl ? reg_wdata[4:0] : ctrl_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= `RXPO_CTRL_RESET;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign half_rate   = ctrl_r[`RXPO_CTRL_RATE];
  assign selftest_on = (ctrl_r[`RXPO_CTRL_ST_HI:`RXPO_CTRL_ST_LO] == `RXPO_SELFTEST_ON);

  // ****************************************************************
  // reclocker powered-down flag
  // ****************************************************************
  // taken from the next enables so it moves with the write, not the link
  assign recl_off_nxt = ~ctrl_nxt[`RXPO_CTRL_OUT1_EN] & ~ctrl_nxt[`RXPO_CTRL_OUT2_EN]; // see R9

  always_ff @(posedge clk) begin
    if (reset) begin
      reclocker_off_flag <= 1'b0;
    end else if (ce) begin
      reclocker_off_flag <= recl_off_nxt; // see R10
    end
  end

  // ****************************************************************
  // forwarding state
  // ****************************************************************
  rxpo_fwd_e fwd_r;
  logic      char_event;
  logic      rate_d_r;
  logic      rate_change;
  logic      stall;
  logic [5:0] stall_cnt_r;

  assign char_event  = link_rise;
  assign rate_change = (half_rate != rate_d_r);
  assign stall       = (stall_cnt_r == 6'(`RXPO_STALL_CYC));

  always_ff @(posedge clk) begin
    if (reset) begin
      rate_d_r <= 1'b0;
    end else if (ce) begin
      rate_d_r <= half_rate;
    end
  end

  // counts clk cycles since the last link edge
  always_ff @(posedge clk) begin
    if (reset) begin
      stall_cnt_r <= '0;
    end else if (ce) begin
      if (link_rise | link_fall) begin
        stall_cnt_r <= '0;
      end else if (!stall) begin
        stall_cnt_r <= stall_cnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fwd_r <= RXPO_IDLE;
    end else if (ce) begin
      case (fwd_r)
        RXPO_IDLE: begin
          if (char_event) begin
            fwd_r <= RXPO_RUN;
          end
        end
        RXPO_RUN: begin
          if (stall) begin
            fwd_r <= RXPO_HOLD;
          end
        end
        RXPO_HOLD: begin
          if (char_event) begin
            fwd_r <= RXPO_RUN;
          end
        end
        default: begin
          fwd_r <= RXPO_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // forwarded clock pair
  // ****************************************************************
  // full rate: high at each character, low at the mid-character link edge.
  // half rate: one toggle per character. a rate change with no character in
  // the same cycle restarts low so the pair never shows a runt phase at the old rate.
  // limitation: a character meeting a high clock at the switch to full
  // rate is dropped, since it could not be marked by a rising edge
  logic fclk_nxt;
  logic fwd_char;

  assign fwd_char = char_event & ~(rate_change & ~half_rate & rx_forwarded_clock_p);

  always_comb begin
    fclk_nxt = rx_forwarded_clock_p;
    if (fwd_char) begin
      if (half_rate) begin
        fclk_nxt = ~rx_forwarded_clock_p; // see R3
      end else begin
        fclk_nxt = 1'b1; // see R2
      end
    end else if (rate_change) begin
      fclk_nxt = 1'b0;
    end else if (!half_rate && link_fall) begin
      fclk_nxt = 1'b0; // see R2
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_forwarded_clock_p <= 1'b0;
      rx_forwarded_clock_n <= 1'b1;
    end else if (ce) begin
      rx_forwarded_clock_p <= fclk_nxt;  // see R11
      rx_forwarded_clock_n <= ~fclk_nxt; // see R2
    end
  end

  // ****************************************************************
  // parallel data and self-test status
  // ****************************************************************
  rxpo_char_t char_nxt;
  logic       st_nxt;

  always_comb begin
    if (selftest_on) begin
      // upper bits carry nothing in self-test, so hold them at zero
      char_nxt = {8'h00, selftest_code[1:0]}; // see R5 see R6 see R12
      st_nxt   = selftest_code[2];            // see R7
    end else begin
      char_nxt = char_s;
      st_nxt   = 1'b0; // see R8
    end
  end

  // data moves with the same cycle as the clock edge that marks it
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_parallel_char_out <= '0;
      selftest_status_out  <= 1'b0;
    end else if (ce) begin
      if (fwd_char) begin
        rx_parallel_char_out <= char_nxt; // see R1 see R4
        selftest_status_out  <= st_nxt;   // see R5
      end
    end
  end

  // ****************************************************************
  // character counter
  // ****************************************************************
  logic [31:0] char_cnt_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      char_cnt_r <= '0;
    end else if (ce) begin
      if (reg_wr & hit(reg_addr, `RXPO_OFS_CHAR_CNT)) begin
        char_cnt_r <= '0;
      end else if (char_event) begin
        char_cnt_r <= char_cnt_r + 32'h1;
      end
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  logic [`RXPO_EV_COUNT-1:0] ev;
  logic [`RXPO_EV_COUNT-1:0] status_r;
  logic [`RXPO_EV_COUNT-1:0] mask_r;
  logic                      code_chg;
  logic [2:0]                code_d_r;
  logic                      stall_d_r;
  logic                      wr_status;

  always_ff @(posedge clk) begin
    if (reset) begin
      code_d_r  <= '0;
      stall_d_r <= 1'b0;
    end else if (ce) begin
      code_d_r  <= selftest_code;
      stall_d_r <= stall;
    end
  end

  assign code_chg  = selftest_on & (selftest_code != code_d_r);
  assign wr_status = reg_wr & hit(reg_addr, `RXPO_OFS_STATUS);

  assign ev[`RXPO_EV_CHAR]      = char_event;
  assign ev[`RXPO_EV_ST_CHANGE] = code_chg;
  assign ev[`RXPO_EV_RECL_OFF]  = recl_off_nxt & ~reclocker_off_flag;
  assign ev[`RXPO_EV_STALL]     = stall & ~stall_d_r;

  // a new event in the clearing cycle wins over the clear
  genvar g;
  generate
    for (g = 0; g < `RXPO_EV_COUNT; g = g + 1) begin : g_sticky
      always_ff @(posedge clk) begin
        if (reset) begin
          status_r[g] <= 1'b0;
        end else if (ce) begin
          if (ev[g]) begin
            status_r[g] <= 1'b1;
          end else if (wr_status & reg_wdata[g]) begin
            status_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_r <= `RXPO_MASK_RESET;
    end else if (ce) begin
      if (reg_wr & hit(reg_addr, `RXPO_OFS_MASK)) begin
        mask_r <= reg_wdata[`RXPO_EV_COUNT-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(status_r & mask_r);
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  logic [31:0] rd_nxt;
  logic [31:0] state_word;

  always_comb begin
    state_word = '0;
    state_word[`RXPO_STATE_RATE] = half_rate;
    state_word[`RXPO_STATE_CLK]  = rx_forwarded_clock_p;
    state_word[`RXPO_STATE_OFF]  = reclocker_off_flag;
    state_word[`RXPO_STATE_RUN]  = (fwd_r == RXPO_RUN);
    state_word[`RXPO_STATE_CODE_HI:`RXPO_STATE_CODE_LO] = selftest_code;
  end

  always_comb begin
    rd_nxt = '0;
    if (reg_rd) begin
      case (reg_addr)
        `RXPO_OFS_CTRL:      rd_nxt = {27'h0, ctrl_r};
        `RXPO_OFS_STATUS:    rd_nxt = {28'h0, status_r};
        `RXPO_OFS_MASK:      rd_nxt = {28'h0, mask_r};
        `RXPO_OFS_STATE:     rd_nxt = state_word;
        `RXPO_OFS_LAST_CHAR: rd_nxt = {22'h0, rx_parallel_char_out};
        `RXPO_OFS_CHAR_CNT:  rd_nxt = char_cnt_r;
        default:             rd_nxt = '0;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= rd_nxt;
    end
  end

endmodule

`default_nettype wire

// [rxpo_cfg.svh]
/*
  constants of the receive parallel output port: register offsets,
  field positions, reset values and timing counts.
  assumes a 10 mhz system clock and byte addresses on the register port.
*/
// Functional notes
// R1 - At full rate, new characters appear when the true forwarded clock rises.
// R2 - At full rate, the forwarded clock pair is complementary at the character rate.
// R3 - At half rate, the forwarded clock pair is complementary at half the character rate.
// R4 - At half rate, a new character appears on every edge of the forwarded clock.
// R5 - In self-test, status shows on the two low data bits plus the status output.
// R6 - In self-test, the host ignores the upper eight data bits.
// R7 - With self-test control at binary 10, the status output shows reception status.
// R8 - With any other self-test control value, the host ignores the status output.
// R9 - The reclocker-off flag is high exactly when both reclocker output enables are 0.
// R10 - The reclocker-off flag follows the enables without waiting for the link clock.
// R11 - The forwarded clock runs continuously at the rate the rate selection picks; the code moves it only on link or rate changes, so it halts with the link.
// R12 - The three-bit self-test status is passed on as an opaque code.
`ifndef RXPO_CFG_SVH
`define RXPO_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define RXPO_OFS_CTRL      8'h00
`define RXPO_OFS_STATUS    8'h04
`define RXPO_OFS_MASK      8'h08
`define RXPO_OFS_STATE     8'h0c
`define RXPO_OFS_LAST_CHAR 8'h10
`define RXPO_OFS_CHAR_CNT  8'h14

// ****************************************************************
// control fields
// ****************************************************************
`define RXPO_CTRL_OUT1_EN  0
`define RXPO_CTRL_OUT2_EN  1
`define RXPO_CTRL_RATE     2
`define RXPO_CTRL_ST_LO    3
`define RXPO_CTRL_ST_HI    4
`define RXPO_CTRL_RESET    5'h03

// ****************************************************************
// status / mask fields
// ****************************************************************
`define RXPO_EV_CHAR       0
`define RXPO_EV_ST_CHANGE  1
`define RXPO_EV_RECL_OFF   2
`define RXPO_EV_STALL      3
`define RXPO_EV_COUNT      4
`define RXPO_MASK_RESET    4'h0

// ****************************************************************
// state register fields
// ****************************************************************
`define RXPO_STATE_RATE    0
`define RXPO_STATE_CLK     1
`define RXPO_STATE_OFF     2
`define RXPO_STATE_RUN     3
`define RXPO_STATE_CODE_LO 4
`define RXPO_STATE_CODE_HI 6

// ****************************************************************
// codes and timing
// ****************************************************************
`define RXPO_SELFTEST_ON   2'h2
`define RXPO_CLK_PERIOD_NS 100
`define RXPO_STALL_NS      4000
`define RXPO_STALL_CYC     ((`RXPO_STALL_NS) / (`RXPO_CLK_PERIOD_NS))

`endif

// [rxpo_pkg.sv]
/*
  types of the receive parallel output port.
  assumes rxpo_cfg.svh supplies the numeric constants; type widths and state encodings are set here.
*/
package rxpo_pkg;

  typedef logic [9:0] rxpo_char_t;
  typedef logic [2:0] rxpo_code_t;

  typedef enum logic [1:0] {
    RXPO_IDLE = 2'b00,
    RXPO_RUN  = 2'b01,
    RXPO_HOLD = 2'b10
  } rxpo_fwd_e;

endpackage

// [rxpo_pin_sync.sv]
/*
  two-flop synchroniser for a group of pins from outside the clock domain.
  assumes each bit is stable long enough to be sampled; bits of a bus are
  only read at a later link edge, after they have settled.
*/
`timescale 1ns/1ps
`default_nettype none

module rxpo_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r   <= '0;
      pin_sync <= '0;
    end else if (ce) begin
      meta_r   <= pin_in;
      pin_sync <= meta_r;
    end
  end

endmodule

`default_nettype wire

// [rxpo_assertions.sv]
/*
  concurrent checks of the receive parallel output port.
  assumes a bind to rxpo_top with ce held high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rxpo_cfg.svh"

module rxpo_assertions (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [2:0]  selftest_code,
  input wire logic [9:0]  rx_parallel_char_out,
  input wire logic        rx_forwarded_clock_p,
  input wire logic        rx_forwarded_clock_n,
  input wire logic        selftest_status_out,
  input wire logic        reclocker_off_flag,
  input wire logic        irq
);
  logic [4:0] ctrl_r;
  logic [3:0] mask_r;
  logic [3:0] calm_r;
  logic       half_on;
  logic       st_on;
  assign half_on = ctrl_r[`RXPO_CTRL_RATE];
  assign st_on   = ctrl_r[4:3] == `RXPO_SELFTEST_ON;

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= `RXPO_CTRL_RESET;
    end else if (reg_wr && reg_addr == `RXPO_OFS_CTRL) begin
      ctrl_r <= reg_wdata[4:0];
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_r <= `RXPO_MASK_RESET;
    end else if (reg_wr && reg_addr == `RXPO_OFS_MASK) begin
      mask_r <= reg_wdata[3:0];
    end
  end
  // status lags its cause, so it is judged only after a quiet spell
  always_ff @(posedge clk) begin
    if (reset || reg_wr || !$stable(selftest_code)) begin
      calm_r <= 4'h0;
    end else if (calm_r != 4'hf) begin
      calm_r <= calm_r + 4'h1;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence p_edge_s;
    !$stable(rx_forwarded_clock_p);
  endsequence

  clock_pair_a: assert property (rx_forwarded_clock_n == !rx_forwarded_clock_p)
    else $error("clock pair not complementary");
  full_rate_a: assert property (!half_on && $stable(ctrl_r)
    && !$stable(rx_parallel_char_out) |-> $rose(rx_forwarded_clock_p))
    else $error("full rate data moved off rising clock");
  half_rate_a: assert property (half_on && $stable(ctrl_r)
    && !$stable(rx_parallel_char_out) |-> !$stable(rx_forwarded_clock_p))
    else $error("half rate data moved off clock edge");
  status_code_a: assert property (st_on && calm_r == 4'hf && $rose(rx_forwarded_clock_p)
    |-> {selftest_status_out, rx_parallel_char_out[1:0]} == selftest_code)
    else $error("self-test code not shown");
  status_quiet_a: assert property (!st_on && calm_r == 4'hf && $rose(rx_forwarded_clock_p)
    |-> !selftest_status_out)
    else $error("status output driven outside self-test");
  recl_flag_a: assert property (reclocker_off_flag == (ctrl_r[1:0] == 2'h0))
    else $error("reclocker flag wrong");
  fwd_run_a: assert property (p_edge_s |-> ##[1:12] p_edge_s)
    else $error("forwarded clock stopped");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  irq_mask_a: assert property (irq |-> $past(mask_r) != 4'h0)
    else $error("interrupt with all sources masked");
endmodule
`default_nettype wire

// [rxpo_host_model.sv]
/*
  host that captures the forwarded characters.
  assumes the bench tells it the rate and self-test modes.
*/
`timescale 1ns/1ps
`default_nettype none

module rxpo_host_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        half_rate,
  input  wire logic        selftest_on,
  input  wire logic        fwd_clk_p,
  input  wire logic [9:0]  char_in,
  input  wire logic        status_in,
  output logic      [9:0]  cap_char,
  output logic             cap_status,
  output logic      [15:0] cap_cnt
);
  logic p_q;
  // ****************************************************************
  // capture, one system clock after the forwarded edge
  // ****************************************************************
  always_ff @(posedge clk) begin
    p_q <= fwd_clk_p;
    if (reset) begin
      cap_cnt <= 16'h0;
    end else if (fwd_clk_p != p_q && (half_rate || fwd_clk_p)) begin
      cap_char   <= selftest_on ? {8'h00, char_in[1:0]} : char_in;
      cap_status <= selftest_on & status_in;
      cap_cnt    <= cap_cnt + 16'h1;
    end
  end
endmodule
`default_nettype wire

// [tb_top.sv]
/*
  self-checking bench of the receive parallel output port.
  assumes rxpo_top, the host model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rxpo_cfg.svh"

module tb_top
  import rxpo_pkg::*;
;
  logic        clk = 1'b0, reset = 1'b1, ce = 1'b1;
  logic        rx_char_clk = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [9:0]  rx_char_in = 10'h0, sent, char_out, cap_char;
  logic [2:0]  selftest_code = 3'h0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        fwd_p, fwd_n, st_out, flag, irq, cap_status, p_q;
  logic        half_on = 1'b0, chk_on = 1'b0;
  logic [1:0]  st_field = 2'h0;
  logic [15:0] cap_cnt, c0;
  int          errors = 0, checks = 0, edges = 0, e0;

  rxpo_top dut (.clk(clk), .reset(reset), .ce(ce), .rx_char_clk(rx_char_clk),
    .rx_char_in(rx_char_in), .selftest_code(selftest_code), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_parallel_char_out(char_out), .rx_forwarded_clock_p(fwd_p),
    .rx_forwarded_clock_n(fwd_n), .selftest_status_out(st_out),
    .reclocker_off_flag(flag), .irq(irq));
  rxpo_host_model host (.clk(clk), .reset(reset), .half_rate(half_on),
    .selftest_on(st_field == 2'h2), .fwd_clk_p(fwd_p), .char_in(char_out),
    .status_in(st_out), .cap_char(cap_char), .cap_status(cap_status), .cap_cnt(cap_cnt));

  always #50 clk = ~clk;
  always @(posedge clk) begin
    p_q <= fwd_p;
    if (p_q !== fwd_p) edges++;
  end

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_char(input logic [9:0] g, input logic [9:0] e);
    chk_word({22'h0, g}, {22'h0, e});
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask
  function automatic logic [9:0] exp_char(input logic [9:0] c);
    return (st_field == 2'h2) ? {8'h00, selftest_code[1:0]} : c;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk_word(reg_rdata & m, e);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************************************
  // link: free-running character clock, 8 clk per character
  // ****************************************************************
  // each rise judges the character captured from the rise before
  initial begin
    forever begin
      repeat (4) @(posedge clk);
      rx_char_clk <= ~rx_char_clk;
      if (rx_char_clk) begin
        rx_char_in <= 10'($urandom);
      end else begin
        if (chk_on) begin
          chk_char(cap_char, exp_char(sent));
          chk_bit(st_out, st_field == 2'h2 && selftest_code[2]);
          chk_bit(cap_status, st_field == 2'h2 && selftest_code[2]);
        end
        sent = rx_char_in;
      end
    end
  end

  initial begin
    #1ms;
    errors++;
    complete_run();
  end

  initial begin
    void'($urandom(47358));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(`RXPO_OFS_CTRL, 32'hffffffff, 32'h3);
    rd(`RXPO_OFS_MASK, 32'hffffffff, 32'h0);
    rd(8'h20, 32'hffffffff, 32'h0);
    for (int i = 3; i >= 0; i--) begin
      wr(`RXPO_OFS_CTRL, 32'(i));
      chk_bit(flag, i == 0);
    end
    $display("test reclocker flag done");
    wr(`RXPO_OFS_MASK, 32'h4);
    repeat (2) @(negedge clk);
    chk_bit(irq, 1'b1);
    wr(`RXPO_OFS_MASK, 32'h0);
    repeat (2) @(negedge clk);
    chk_bit(irq, 1'b0);
    wr(`RXPO_OFS_MASK, 32'h4);
    wr(`RXPO_OFS_STATUS, 32'h4);
    repeat (2) @(negedge clk);
    chk_bit(irq, 1'b0);
    rd(`RXPO_OFS_STATUS, 32'h4, 32'h0);
    $display("test interrupt done");
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      selftest_code <= 3'($urandom);
      half_on  <= m[0];
      st_field <= m[2:1];
      wr(`RXPO_OFS_CTRL, {27'h0, m[2:1], m[0], 2'h3});
      repeat (3) @(negedge rx_char_clk);
      chk_on = 1'b1;
      e0 = edges;
      c0 = cap_cnt;
      repeat (6) @(negedge rx_char_clk);
      chk_on = 1'b0;
      chk_word(32'(edges - e0), half_on ? 32'h6 : 32'hc);
      chk_word(32'(cap_cnt - c0), 32'h6);
      rd(`RXPO_OFS_STATE, 32'h7d, {25'h0, selftest_code, 3'h4, m[0]});
      $display("test mode %0d done", m);
    end
    complete_run();
  end
endmodule

bind rxpo_top rxpo_assertions u_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .selftest_code(selftest_code), .rx_parallel_char_out(rx_parallel_char_out),
  .rx_forwarded_clock_p(rx_forwarded_clock_p), .rx_forwarded_clock_n(rx_forwarded_clock_n),
  .selftest_status_out(selftest_status_out), .reclocker_off_flag(reclocker_off_flag),
  .irq(irq));
`default_nettype wire
